// ### logic/cpg_phase_gen.sv
/*
 * Switching reference counter and phase-shifted switching pulse.
 * Assumes period and offset are settled values below 2^16 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module cpg_phase_gen (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	cpg_sw_if.gen sw
);
	import cpg_pkg::*;
	logic [15:0] cnt, next_cnt;
	logic sw_q, next_sw;
	logic ref_q, next_ref;

	////////////////////////////////////////////////////////////////
	// Reference counter; a follower restarts on the received edge
	always_comb begin
		next_cnt = cnt + 16'h0001;
		if (sw.follow && sw.sync_edge) begin
			next_cnt = 16'h0000;
		end else if (cnt >= sw.period - 16'h0001) begin
			next_cnt = 16'h0000;
		end
		next_ref = (next_cnt == 16'h0000);
		next_sw = (next_cnt == sw.offset);
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt <= 16'h0000;
			sw_q <= 1'b0;
			ref_q <= 1'b0;
		end else begin
			cnt <= next_cnt;
			sw_q <= next_sw;
			ref_q <= next_ref;
		end
	end

	assign sw.sw_pulse = sw_q;
	assign sw.ref_pulse = ref_q;

	////////////////////////////////////////////////////////////////
	// Checks
	AST_SW_AT_OFFSET: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i) sw_q |-> cnt == $past(sw.offset))
		else $error("switching pulse away from phase offset");
	AST_FOLLOW_REF: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i) (sw.follow && sw.sync_edge)
		|=> (cnt == 16'h0000) && ref_q)
		else $error("follower did not restart on sync edge");
	COV_FOLLOW_SW: cover property (@(posedge clk_sys_i)
		disable iff (!resetn_i) sw.follow && sw_q);
endmodule
`default_nettype wire

// ### logic/cpg_pkg.sv
/*
 * Shared constants and types of the converter supervisory block.
 * Assumes a 100 MHz system clock and 8-bit command codes.
 */
`default_nettype none
package cpg_pkg;
	// Command codes
	localparam logic [7:0] CMD_SETPOINT = 8'h21;
	localparam logic [7:0] CMD_SLEW = 8'h27;
	localparam logic [7:0] CMD_FREQ = 8'h33;
	localparam logic [7:0] CMD_INTERLEAVE = 8'h37;
	localparam logic [7:0] CMD_PG_ON = 8'h5E;
	localparam logic [7:0] CMD_PG_OFF = 8'h5F;
	localparam logic [7:0] CMD_STATUS = 8'h79;
	localparam logic [7:0] CMD_POLARITY = 8'hD0;
	localparam logic [7:0] CMD_TUNE_BASE = 8'hE0;
	localparam logic [7:0] CMD_ADDR_OFS = 8'hEE;
	localparam logic [7:0] CMD_LEVEL_CFG = 8'hEF;
	localparam logic [7:0] CMD_CAP_CFG = 8'hF7;
	localparam logic [7:0] CMD_PIN_CFG = 8'hF9;
	// Tuning table word indices
	localparam int TUNE_WORDS = 13;
	localparam int T_I1H = 0;
	localparam int T_I1L = 1;
	localparam int T_I2H = 2;
	localparam int T_I2L = 3;
	localparam int T_V1 = 4;
	localparam int T_V2 = 5;
	localparam int T_LIM1 = 6;
	localparam int T_LIM2 = 7;
	localparam int T_LIM3 = 8;
	localparam int T_K1 = 9;
	localparam int T_K2 = 10;
	localparam int T_K3 = 11;
	localparam int T_RISE = 12;
	// Reset values and frequency limits
	localparam logic [15:0] RST_INTERLEAVE = 16'h0021;
	localparam logic [7:0] RST_POLARITY = 8'h00;
	localparam logic [7:0] RST_PIN_ALONE = 8'h04;
	localparam logic [7:0] RST_PIN_PARALLEL = 8'h06;
	localparam logic [15:0] RST_FREQ_KHZ = 16'h00B4;
	localparam logic [15:0] FREQ_MIN_KHZ = 16'h00A0;
	localparam logic [15:0] FREQ_MAX_KHZ = 16'h00C8;
	localparam logic [15:0] RST_PG_ON_MV = 16'h1F40;
	localparam logic [15:0] RST_PG_OFF_MV = 16'h1388;
	localparam logic [15:0] RST_SETPOINT_MV = 16'h2EE0;
	// Field positions
	localparam int IL_ORDER_LSB = 0;
	localparam int IL_NUM_LSB = 4;
	localparam int PIN_SYNC_EN = 0;
	localparam int PIN_PG_OD = 1;
	localparam int PIN_PG_EN = 2;
	localparam int PIN_SYNC_SA1 = 3;
	localparam int PIN_SYNC_OUT = 4;
	localparam logic [1:0] POL_ACTIVE_HIGH = 2'h1;
	localparam int LVL_EN = 0;
	localparam int CAP_ART_EN = 0;
	localparam int CAP_DLC_EN = 1;
	localparam int STATUS_PG_BIT = 11;
	localparam int FACTOR_FRAC = 4;
	localparam int TOL_SHIFT = 4;
	// Timing
	localparam int CLK_KHZ = 100000;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = TICK_NS * CLK_KHZ / 1000000;
	localparam int SYNC_HIGH_NS = 250;
	localparam int SYNC_HIGH_CYCLES = (SYNC_HIGH_NS * CLK_KHZ + 999999) / 1000000;
	typedef enum {LVL_LOW, LVL_MID, LVL_HIGH} cpg_level_t;
endpackage
`default_nettype wire

// ### logic/cpg_sw_if.sv
/*
 * Carrier between the configuration top and the phase generator.
 * Assumes both ends run on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface cpg_sw_if;
	logic [15:0] period;
	logic [15:0] offset;
	logic follow;
	logic sync_edge;
	logic sw_pulse;
	logic ref_pulse;
	modport cfg(output period, offset, follow, sync_edge,
		input sw_pulse, ref_pulse);
	modport gen(input period, offset, follow, sync_edge,
		output sw_pulse, ref_pulse);
endinterface
`default_nettype wire

// ### logic/cpg_top.sv
/*
 * Supervisory and configuration logic: command registers, phase
 * spread, power-good pin and flag, load-based levels with slew,
 * adaptive rise time, loop tuning and bus address.
 * Assumes commands, measurements and faults arrive on clk_sys_i;
 * the two pins come from outside and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
module cpg_top #(
	parameter bit PARALLEL_VARIANT = 1'b0,
	parameter logic [6:0] ADDR_BASE = 7'h20
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_write_i,
	input wire logic [7:0] cmd_code_i,
	input wire logic [15:0] cmd_wdata_i,
	output logic rsp_valid_o,
	output logic [15:0] rsp_data_o,
	output logic rsp_error_o,
	input wire logic [15:0] vout_mv_i,
	input wire logic [15:0] iout_ma_i,
	input wire logic ramping_i,
	input wire logic fault_i,
	input wire logic ramp_start_i,
	input wire logic cap_valid_i,
	input wire logic [15:0] cap_meas_i,
	input wire logic [2:0] sa0_code_i,
	input wire logic [2:0] sa1_code_i,
	input wire logic good_or_sync_pin_i,
	output logic good_or_sync_pin_o,
	output logic good_or_sync_pin_oe_o,
	input wire logic second_address_pin_i,
	output logic second_address_pin_o,
	output logic second_address_pin_oe_o,
	output logic sw_pulse_o,
	output logic [15:0] vout_target_o,
	output logic [15:0] rise_time_o,
	output logic loop_alt_o,
	output logic [6:0] bus_addr_o
);
	import cpg_pkg::*;

	if (TICK_CYCLES < 1 || SYNC_HIGH_CYCLES < 1) begin : g_chk
		$error("clock too slow for timing counts");
	end

	localparam logic [7:0] RST_PIN = PARALLEL_VARIANT ?
		RST_PIN_PARALLEL : RST_PIN_ALONE;

	function automatic logic tune_hit(input logic [7:0] code);
		tune_hit = code >= CMD_TUNE_BASE &&
			code < CMD_TUNE_BASE + 8'(TUNE_WORDS);
	endfunction

	function automatic logic [15:0] absdiff(input logic [15:0] a,
		input logic [15:0] b);
		absdiff = (a > b) ? a - b : b - a;
	endfunction

	////////////////////////////////////////////////////////////////
	// Command registers
	logic [15:0] setpoint, next_setpoint, slew, next_slew;
	logic [15:0] freq, next_freq, ilv, next_ilv;
	logic [15:0] pg_on, next_pg_on, pg_off, next_pg_off;
	logic [7:0] pol, next_pol, addr_ofs, next_addr_ofs;
	logic [7:0] lvl_cfg, next_lvl_cfg, cap_cfg, next_cap_cfg;
	logic [7:0] pin_cfg, next_pin_cfg;
	logic [15:0] tune [TUNE_WORDS];
	logic [15:0] next_tune [TUNE_WORDS];
	logic status_pg;
	logic [15:0] rdata;
	logic rerr;
	logic wr;

	assign wr = cmd_valid_i && cmd_write_i;

	// Writes; an out-of-range frequency is ignored
	always_comb begin
		next_setpoint = setpoint;
		next_slew = slew;
		next_freq = freq;
		next_ilv = ilv;
		next_pg_on = pg_on;
		next_pg_off = pg_off;
		next_pol = pol;
		next_addr_ofs = addr_ofs;
		next_lvl_cfg = lvl_cfg;
		next_cap_cfg = cap_cfg;
		next_pin_cfg = pin_cfg;
		next_tune = tune;
		if (wr) begin
			case (cmd_code_i)
				CMD_SETPOINT: next_setpoint = cmd_wdata_i;
				CMD_SLEW: next_slew = cmd_wdata_i;
				CMD_FREQ: begin
					if (cmd_wdata_i >= FREQ_MIN_KHZ &&
						cmd_wdata_i <= FREQ_MAX_KHZ) begin
						next_freq = cmd_wdata_i;
					end
				end
				CMD_INTERLEAVE: next_ilv = cmd_wdata_i;
				CMD_PG_ON: next_pg_on = cmd_wdata_i;
				CMD_PG_OFF: next_pg_off = cmd_wdata_i;
				CMD_POLARITY: next_pol = cmd_wdata_i[7:0];
				CMD_ADDR_OFS: next_addr_ofs = cmd_wdata_i[7:0];
				CMD_LEVEL_CFG: next_lvl_cfg = cmd_wdata_i[7:0];
				CMD_CAP_CFG: next_cap_cfg = cmd_wdata_i[7:0];
				CMD_PIN_CFG: next_pin_cfg = cmd_wdata_i[7:0];
				default: begin
					if (tune_hit(cmd_code_i)) begin
						next_tune[4'(cmd_code_i - CMD_TUNE_BASE)] = cmd_wdata_i;
					end
				end
			endcase
		end
	end

	// Read mux; unknown codes answer zero with an error flag
	always_comb begin
		rdata = 16'h0000;
		rerr = 1'b0;
		case (cmd_code_i)
			CMD_SETPOINT: rdata = setpoint;
			CMD_SLEW: rdata = slew;
			CMD_FREQ: rdata = freq;
			CMD_INTERLEAVE: rdata = ilv;
			CMD_PG_ON: rdata = pg_on;
			CMD_PG_OFF: rdata = pg_off;
			CMD_STATUS: rdata[STATUS_PG_BIT] = status_pg;
			CMD_POLARITY: rdata = {8'h00, pol};
			CMD_ADDR_OFS: rdata = {8'h00, addr_ofs};
			CMD_LEVEL_CFG: rdata = {8'h00, lvl_cfg};
			CMD_CAP_CFG: rdata = {8'h00, cap_cfg};
			CMD_PIN_CFG: rdata = {8'h00, pin_cfg};
			default: begin
				if (tune_hit(cmd_code_i)) begin
					rdata = tune[4'(cmd_code_i - CMD_TUNE_BASE)];
				end else begin
					rerr = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			setpoint <= RST_SETPOINT_MV;
			slew <= 16'h0000;
			freq <= RST_FREQ_KHZ;
			ilv <= RST_INTERLEAVE;
			pg_on <= RST_PG_ON_MV;
			pg_off <= RST_PG_OFF_MV;
			pol <= RST_POLARITY;
			addr_ofs <= 8'h00;
			lvl_cfg <= 8'h00;
			cap_cfg <= 8'h00;
			pin_cfg <= RST_PIN;
			for (int i = 0; i < TUNE_WORDS; i++) begin
				tune[i] <= 16'h0000;
			end
			rsp_valid_o <= 1'b0;
			rsp_data_o <= 16'h0000;
			rsp_error_o <= 1'b0;
		end else begin
			setpoint <= next_setpoint;
			slew <= next_slew;
			freq <= next_freq;
			ilv <= next_ilv;
			pg_on <= next_pg_on;
			pg_off <= next_pg_off;
			pol <= next_pol;
			addr_ofs <= next_addr_ofs;
			lvl_cfg <= next_lvl_cfg;
			cap_cfg <= next_cap_cfg;
			pin_cfg <= next_pin_cfg;
			tune <= next_tune;
			rsp_valid_o <= cmd_valid_i;
			rsp_data_o <= cmd_write_i ? 16'h0000 : rdata;
			rsp_error_o <= cmd_valid_i && rerr;
		end
	end

	////////////////////////////////////////////////////////////////
	// Power good state, flag and level selection with slew
	logic pg_state, next_pg_state, next_status_pg;
	cpg_level_t level, next_level;
	logic [15:0] goal, tgt, next_tgt;
	logic [7:0] tick_cnt, next_tick_cnt;

	always_comb begin
		next_pg_state = pg_state;
		if (ramping_i || fault_i) begin
			next_pg_state = 1'b0;
		end else if (!pg_state && vout_mv_i > pg_on) begin
			next_pg_state = 1'b1;
		end else if (pg_state && vout_mv_i < pg_off) begin
			next_pg_state = 1'b0;
		end
		next_status_pg = !fault_i && !ramping_i &&
			absdiff(vout_mv_i, tgt) <= (tgt >> TOL_SHIFT);
		next_level = level;
		case (level)
			LVL_LOW: if (iout_ma_i > tune[T_I1H]) next_level = LVL_MID;
			LVL_MID: begin
				if (iout_ma_i < tune[T_I1L]) begin
					next_level = LVL_LOW;
				end else if (iout_ma_i > tune[T_I2H]) begin
					next_level = LVL_HIGH;
				end
			end
			LVL_HIGH: if (iout_ma_i < tune[T_I2L]) next_level = LVL_MID;
			default: next_level = LVL_HIGH;
		endcase
		if (!lvl_cfg[LVL_EN]) begin
			next_level = LVL_HIGH;
		end
		case (level)
			LVL_LOW: goal = tune[T_V1];
			LVL_MID: goal = tune[T_V2];
			default: goal = setpoint;
		endcase
		next_tick_cnt = (tick_cnt == 8'(TICK_CYCLES - 1)) ?
			8'h00 : tick_cnt + 8'h01;
		next_tgt = tgt;
		if (slew == 16'h0000 || absdiff(goal, tgt) <= slew) begin
			if (slew == 16'h0000 || tick_cnt == 8'h00) next_tgt = goal;
		end else if (tick_cnt == 8'h00) begin
			next_tgt = (goal > tgt) ? tgt + slew : tgt - slew;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pg_state <= 1'b0;
			status_pg <= 1'b0;
			level <= LVL_HIGH;
			tgt <= RST_SETPOINT_MV;
			tick_cnt <= 8'h00;
		end else begin
			pg_state <= next_pg_state;
			status_pg <= next_status_pg && next_pg_state;
			level <= next_level;
			tgt <= next_tgt;
			tick_cnt <= next_tick_cnt;
		end
	end

	assign vout_target_o = tgt;

	////////////////////////////////////////////////////////////////
	// Adaptive rise time and loop tuning from measured capacitance
	logic [15:0] next_rise;
	logic next_loop;
	logic [15:0] k;

	always_comb begin
		next_rise = rise_time_o;
		next_loop = loop_alt_o;
		k = 16'h0000;
		if (cap_meas_i > tune[T_LIM3]) k = tune[T_K3];
		else if (cap_meas_i > tune[T_LIM2]) k = tune[T_K2];
		else if (cap_meas_i > tune[T_LIM1]) k = tune[T_K1];
		if (ramp_start_i) begin
			next_rise = tune[T_RISE];
		end else if (cap_valid_i && cap_cfg[CAP_ART_EN] &&
			k != 16'h0000) begin
			next_rise = 16'((32'(tune[T_RISE]) * 32'(k)) >> FACTOR_FRAC);
		end
		if (cap_valid_i) begin
			next_loop = cap_cfg[CAP_DLC_EN] && cap_meas_i > tune[T_LIM3];
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rise_time_o <= 16'h0000;
			loop_alt_o <= 1'b0;
		end else begin
			rise_time_o <= next_rise;
			loop_alt_o <= next_loop;
		end
	end

	////////////////////////////////////////////////////////////////
	// Sync, phase spread, pins and bus address
	cpg_sw_if sw ();
	logic pg_s1, pg_s2, sa_s1, sa_s2, sync_prev;
	logic sync_en, sync_sa1, sync_drive, sync_sel, pg_lvl;
	logic [15:0] next_period, next_offset;
	logic [4:0] sync_cnt, next_sync_cnt;
	logic next_pg_o, next_pg_oe, next_sa_o, next_sa_oe;
	logic [6:0] next_addr;
	logic [3:0] il_num, il_ord;

	assign sync_en = pin_cfg[PIN_SYNC_EN];
	assign sync_sa1 = sync_en && pin_cfg[PIN_SYNC_SA1];
	assign sync_drive = pin_cfg[PIN_SYNC_OUT];
	assign sync_sel = sync_sa1 ? sa_s2 : pg_s2;
	assign il_num = ilv[IL_NUM_LSB +: 4];
	assign il_ord = ilv[IL_ORDER_LSB +: 4];
	assign pg_lvl = (pol[1:0] == POL_ACTIVE_HIGH) ? pg_state : !pg_state;

	always_comb begin
		next_period = 16'(CLK_KHZ / int'(freq));
		// offset cycles from position over count
		next_offset = (il_num == 4'h0) ? 16'h0000 :
			16'((32'(sw.period) * 32'(il_ord)) / 32'(il_num));
		next_sync_cnt = (sync_cnt != 5'h00) ? sync_cnt - 5'h01 : 5'h00;
		if (sw.ref_pulse && sync_drive) begin
			next_sync_cnt = 5'(SYNC_HIGH_CYCLES);
		end
		next_pg_o = 1'b0;
		next_pg_oe = 1'b0;
		if (sync_en && !sync_sa1) begin
			next_pg_o = (sync_cnt != 5'h00);
			next_pg_oe = sync_drive;
		end else if (pin_cfg[PIN_PG_EN]) begin
			next_pg_oe = pin_cfg[PIN_PG_OD] ? !pg_lvl : 1'b1;
			next_pg_o = pin_cfg[PIN_PG_OD] ? 1'b0 : pg_lvl;
		end
		next_sa_o = sync_sa1 && sync_drive && (sync_cnt != 5'h00);
		next_sa_oe = sync_sa1 && sync_drive;
		next_addr = ADDR_BASE + (sync_sa1 ?
			7'(sa0_code_i) + addr_ofs[6:0] : {1'b0, sa1_code_i, sa0_code_i});
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pg_s1 <= 1'b0;
			pg_s2 <= 1'b0;
			sa_s1 <= 1'b0;
			sa_s2 <= 1'b0;
			sync_prev <= 1'b0;
			sw.period <= 16'h0001;
			sw.offset <= 16'h0000;
			sync_cnt <= 5'h00;
			good_or_sync_pin_o <= 1'b0;
			good_or_sync_pin_oe_o <= 1'b0;
			second_address_pin_o <= 1'b0;
			second_address_pin_oe_o <= 1'b0;
			bus_addr_o <= ADDR_BASE;
		end else begin
			pg_s1 <= good_or_sync_pin_i;
			pg_s2 <= pg_s1;
			sa_s1 <= second_address_pin_i;
			sa_s2 <= sa_s1;
			sync_prev <= sync_sel;
			sw.period <= next_period;
			sw.offset <= next_offset;
			sync_cnt <= next_sync_cnt;
			good_or_sync_pin_o <= next_pg_o;
			good_or_sync_pin_oe_o <= next_pg_oe;
			second_address_pin_o <= next_sa_o;
			second_address_pin_oe_o <= next_sa_oe;
			bus_addr_o <= next_addr;
		end
	end

	// Follower restarts on any synchronised rising edge
	assign sw.follow = sync_en && !sync_drive;
	assign sw.sync_edge = sync_sel && !sync_prev;
	assign sw_pulse_o = sw.sw_pulse;

	cpg_phase_gen u_gen (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.sw(sw)
	);

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	AST_PG_HELD: assert property ((ramping_i || fault_i) |=> !pg_state)
		else $error("power good active during ramp or fault");
	AST_PG_ON: assert property ((!ramping_i && !fault_i && !pg_state &&
		vout_mv_i > pg_on) |=> pg_state)
		else $error("power good missed on threshold");
	AST_PG_OFF: assert property ((pg_state && vout_mv_i < pg_off)
		|=> !pg_state)
		else $error("power good missed off threshold");
	// First edge after reset still shows the reset drive on the pin
	AST_PG_PP: assert property (($past(resetn_i) &&
		$past(pin_cfg[PIN_PG_EN]) &&
		!$past(pin_cfg[PIN_SYNC_EN]) && !$past(pin_cfg[PIN_PG_OD]))
		|-> good_or_sync_pin_oe_o && (good_or_sync_pin_o ==
		($past(pg_state) == ($past(pol[1:0]) == POL_ACTIVE_HIGH))))
		else $error("push-pull level or polarity wrong");
	AST_PG_OD: assert property ((!$past(sync_en) && $past(pin_cfg[PIN_PG_OD])
		&& good_or_sync_pin_oe_o) |-> !good_or_sync_pin_o)
		else $error("open-drain pin driven high");
	AST_FREQ_RANGE: assert property (freq >= FREQ_MIN_KHZ &&
		freq <= FREQ_MAX_KHZ)
		else $error("switching frequency out of range");
	AST_STATUS_FAULT: assert property (fault_i |=> !status_pg)
		else $error("status flag set under fault");
	AST_LEVEL_UP: assert property ((lvl_cfg[LVL_EN] && level == LVL_LOW &&
		iout_ma_i > tune[T_I1H]) |=> level == LVL_MID)
		else $error("level did not step up");
	AST_SLEW: assert property ((tgt != $past(tgt) && $past(slew) != 16'h0000)
		|-> absdiff(tgt, $past(tgt)) <= $past(slew))
		else $error("target moved faster than slew");
	AST_RISE_NOM: assert property (ramp_start_i |=> rise_time_o ==
		$past(tune[T_RISE]))
		else $error("ramp did not start at nominal rise");
	AST_LOOP: assert property (cap_valid_i |=> loop_alt_o ==
		($past(cap_cfg[CAP_DLC_EN]) && $past(cap_meas_i) >
		$past(tune[T_LIM3])))
		else $error("loop change against third limit wrong");
	AST_ADDR: assert property ((sync_sa1 && $stable(sa0_code_i) &&
		$stable(addr_ofs)) |=> bus_addr_o == 7'(ADDR_BASE +
		7'($past(sa0_code_i)) + $past(addr_ofs[6:0])))
		else $error("offset address wrong");
	COV_PG: cover property (!pg_state ##1 pg_state);
	COV_LEVEL_HIGH: cover property (level == LVL_MID ##1 level == LVL_HIGH);
	COV_LOOP: cover property ($rose(loop_alt_o));
endmodule
`default_nettype wire

// ### tb/cpg_sync_partner.sv
/* Sibling converter leading the shared sync line.
   Assumes the bench resolves the pin with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module cpg_sync_partner (
	input wire logic link_clk_i,
	input wire logic en_i,
	output logic sync_o,
	output logic sync_oe_o
);
	int cnt = 0;
	initial sync_o = 0;
	initial sync_oe_o = 0;
	// one shared reference
	// Releases the line when not leading, so no stale level lingers
	always @(posedge link_clk_i) begin
		cnt <= (cnt == 43) ? 0 : cnt + 1;
		sync_oe_o <= en_i;
		sync_o <= en_i && cnt < 2;
	end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
/* Self-checking bench: commands, pins, levels, rise time, sync.
   Assumes pull-ups on both shared pins. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import cpg_pkg::*;
	logic clk_sys_i = 0, resetn_i = 0, link_clk = 0, cmd_valid_i = 0;
	logic cmd_write_i = 0, ramping_i = 0, fault_i = 0, ramp_start_i = 0;
	logic cap_valid_i = 0, p_en = 0, err, rsp_valid_o, rsp_error_o;
	logic [7:0] cmd_code_i = 0;
	logic [15:0] cmd_wdata_i = 0, vout_mv_i = 0, iout_ma_i = 0;
	logic [15:0] cap_meas_i = 0, rdata, rsp_data_o;
	logic [15:0] vout_target_o, rise_time_o;
	logic [2:0] sa0_code_i = 1, sa1_code_i = 2;
	logic good_or_sync_pin_o, good_or_sync_pin_oe_o, p_o, p_oe, pin12;
	logic second_address_pin_o, second_address_pin_oe_o, pin9;
	logic sw_pulse_o, loop_alt_o;
	logic [6:0] bus_addr_o;
	logic [23:0] tune [15] = '{24'hE003E8, 24'hE10320, 24'hE21388,
		24'hE30BB8, 24'hE41000, 24'hE52000, 24'hE6000A, 24'hE7001E,
		24'hE80032, 24'hE90020, 24'hEA0018, 24'hEB0030, 24'hEC0064,
		24'hEF0001, 24'hF70003};
	int n_errors = 0, n_compared = 0, k, n;
	// Link clock has no phase relation to the system clock
	always #5 clk_sys_i = ~clk_sys_i;
	always #62.5 link_clk = ~link_clk;
	// Shared pins: our driver wins over the sibling's, otherwise the pull-up
	assign pin12 = good_or_sync_pin_oe_o ? good_or_sync_pin_o :
		p_oe ? p_o : 1'b1;
	assign pin9 = second_address_pin_oe_o ? second_address_pin_o : 1'b1;
	cpg_top dut (.clk_sys_i, .resetn_i, .cmd_valid_i, .cmd_write_i,
		.cmd_code_i, .cmd_wdata_i, .rsp_valid_o, .rsp_data_o, .rsp_error_o,
		.vout_mv_i, .iout_ma_i, .ramping_i, .fault_i, .ramp_start_i,
		.cap_valid_i, .cap_meas_i, .sa0_code_i, .sa1_code_i,
		.good_or_sync_pin_i(pin12), .good_or_sync_pin_o,
		.good_or_sync_pin_oe_o, .second_address_pin_i(pin9),
		.second_address_pin_o, .second_address_pin_oe_o, .sw_pulse_o,
		.vout_target_o, .rise_time_o, .loop_alt_o, .bus_addr_o);
	cpg_sync_partner partner (.link_clk_i(link_clk), .en_i(p_en),
		.sync_o(p_o), .sync_oe_o(p_oe));
	////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] s, e);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("wrong value %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic tick(input int c);
		repeat (c) @(negedge clk_sys_i);
	endtask
	// Idle cycle after each command keeps strobe edges apart
	task automatic cmd(input logic wr, input logic [7:0] c,
		input logic [15:0] d);
		cmd_write_i = wr;
		cmd_code_i = c;
		cmd_wdata_i = d;
		cmd_valid_i = 1;
		tick(1);
		rdata = rsp_data_o;
		err = rsp_error_o;
		chk("answer", 16'(rsp_valid_o), 1);
		cmd_valid_i = 0;
		tick(1);
	endtask
	task automatic rd(input string nm, input logic [7:0] c,
		input logic [15:0] e);
		cmd(0, c, 0);
		chk(nm, rdata, e);
	endtask
	task automatic pg(input logic [15:0] mv, input logic rp, f,
		input logic [1:0] pin, input logic flag);
		vout_mv_i = mv;
		ramping_i = rp;
		fault_i = f;
		tick(3);
		chk("pg pin", 16'({good_or_sync_pin_oe_o, good_or_sync_pin_o}),
			16'(pin));
		cmd(0, CMD_STATUS, 0);
		chk("pg flag", 16'(rdata[STATUS_PG_BIT]), 16'(flag));
	endtask
	task automatic lvl(input logic [15:0] ma, t);
		iout_ma_i = ma;
		tick(3);
		chk("target", vout_target_o, t);
	endtask
	task automatic adaptive_ramp_time(input logic [15:0] c, r, input logic alt);
		ramp_start_i = 1;
		tick(1);
		ramp_start_i = 0;
		tick(1);
		chk("nominal rise", rise_time_o, 16'h0064);
		cap_meas_i = c;
		cap_valid_i = 1;
		tick(1);
		cap_valid_i = 0;
		tick(1);
		chk("scaled rise", rise_time_o, r);
		chk("loop alt", 16'(loop_alt_o), 16'(alt));
	endtask
	// Waits for a level on pin 12, or pin 9 when on9 is set;
	// k ends as the number of cycles waited
	task automatic until_pin(input logic on9, val, input int lim);
		for (k = 0; k < lim && (on9 ? pin9 : pin12) !== val; k++) tick(1);
		if (k == lim) begin
			n_errors++;
			complete_run();
		end
	endtask
	// Cycles from the sibling's rising edge to our switching pulse
	task automatic sync_lag(input logic [15:0] il, input int e);
		cmd(1, CMD_INTERLEAVE, il);
		until_pin(0, 0, 2000);
		until_pin(0, 1, 2000);
		for (n = 0; n < 2000 && sw_pulse_o !== 1; n++) tick(1);
		chk("sync lag", 16'(n >= e - 2 && n <= e + 3), 1);
		if (n == 2000)
			complete_run();
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		tick(2);
		resetn_i = 1;
		rd("interleave", CMD_INTERLEAVE, 16'h0021);
		rd("pin config", CMD_PIN_CFG, 16'h0004);
		rd("polarity", CMD_POLARITY, 16'h0000);
		rd("pg on", CMD_PG_ON, 16'h1F40);
		rd("pg off", CMD_PG_OFF, 16'h1388);
		rd("freq", CMD_FREQ, 16'h00B4);
		cmd(0, 8'h00, 0);
		chk("unmapped", 16'(err), 1);
		cmd(1, CMD_FREQ, 16'h00C9);
		rd("freq", CMD_FREQ, 16'h00B4);
		cmd(1, CMD_FREQ, 16'h00A0);
		rd("freq", CMD_FREQ, 16'h00A0);
		cmd(1, CMD_FREQ, 16'h00B4);
		// Good pin and flag through fault, ramp and hysteresis
		pg(16'h2EE0, 0, 0, 2'b10, 1);
		pg(16'h2EE0, 1, 0, 2'b11, 0);
		pg(16'h2EE0, 0, 1, 2'b11, 0);
		pg(16'h2328, 0, 0, 2'b10, 0);
		pg(16'h1770, 0, 0, 2'b10, 0);
		pg(16'h0FA0, 0, 0, 2'b11, 0);
		pg(16'h1770, 0, 0, 2'b11, 0);
		cmd(1, CMD_POLARITY, 16'h0001);
		pg(16'h2EE0, 0, 0, 2'b11, 1);
		cmd(1, CMD_PIN_CFG, 16'h0006);
		pg(16'h2EE0, 0, 0, 2'b00, 1);
		pg(16'h0FA0, 0, 0, 2'b10, 0);
		// Levels by load current, then a slewed move down
		foreach (tune[i]) cmd(1, tune[i][23:16], tune[i][15:0]);
		lvl(16'h0000, 16'h1000);
		lvl(16'h07D0, 16'h2000);
		lvl(16'h1770, 16'h2EE0);
		cmd(1, CMD_SLEW, 16'h0010);
		iout_ma_i = 16'h07D0;
		tick(250);
		chk("slew", 16'(vout_target_o inside {[16'h2EB0:16'h2ED0]}), 1);
		adaptive_ramp_time(16'h0014, 16'h00C8, 0);
		adaptive_ramp_time(16'h003C, 16'h012C, 1);
		// Address from both pins, then first pin plus offset
		chk("address", 16'(bus_addr_o), 16'h0031);
		cmd(1, CMD_ADDR_OFS, 16'h0005);
		cmd(1, CMD_PIN_CFG, 16'h0009);
		tick(1);
		chk("address", 16'(bus_addr_o), 16'h0026);
		p_en = 1;
		cmd(1, CMD_PIN_CFG, 16'h0001);
		sync_lag(16'h0021, 280);
		sync_lag(16'h0041, 141);
		// Leading the line: pulse width in system cycles, pin 12 then 9
		p_en = 0;
		cmd(1, CMD_PIN_CFG, 16'h0011);
		until_pin(0, 0, 2000);
		until_pin(0, 1, 2000);
		until_pin(0, 0, 100);
		chk("sync width", 16'(k), 16'h0019);
		cmd(1, CMD_PIN_CFG, 16'h0019);
		until_pin(1, 0, 2000);
		until_pin(1, 1, 2000);
		until_pin(1, 0, 100);
		chk("sync width pin9", 16'(k), 16'h0019);
		chk("pin12 oe", 16'(good_or_sync_pin_oe_o), 16'h0000);
		complete_run();
	end
endmodule
`default_nettype wire
